/* File: rtl/sci_core.sv */
// Command interpreter behind the serial slave port of the decoder.
// Assumes bytes arrive already framed, one cycle each, on core_clk.
`timescale 1ns/100ps
module sci_core
    import sci_pkg::*;
#(
    parameter int PIN_COUNT = 8
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    input  wire sci_host_t            host,
    input  wire logic                 rdReq,
    input  wire sci_fw_t              fw,
    input  wire logic                 frameSyncEvent,
    input  wire logic [PIN_COUNT-1:0] pioPins,
    output sci_rsp_t                  rsp,
    output logic                      audioMute,
    output logic                      frameSyncPin,
    output logic                      decodeHalted,
    output logic                      runStrobe,
    output logic [15:0]               runAddr,
    output logic                      cfgOverride,
    output logic                      clkCfgActivate
);
    logic                 softRst;
    logic                 rst;
    logic [PIN_COUNT-1:0] pinS1, pinS2, pinS3, pinLevel;
    logic [19:0]          regFile [REG_COUNT];
    logic [19:0]          mem0 [MEM_WORDS];
    logic [19:0]          mem1 [MEM_WORDS];
    logic [15:0]          statArr [STAT_WORDS];
    sci_state_t           state, next_state;
    sci_rdmode_t          rdMode, next_rdMode;
    logic                 wrHi, next_wrHi;
    logic [7:0]           hiByte, next_hiByte;
    logic [7:0]           regNum, next_regNum;
    logic [3:0]           d0Nib, next_d0Nib;
    logic                 memSel, next_memSel;
    logic                 memRead, next_memRead;
    logic [15:0]          count, next_count;
    logic [10:0]          addr, next_addr;
    logic [15:0]          lowWord, next_lowWord;
    logic                 rdHi, next_rdHi;
    logic                 rdSecond, next_rdSecond;
    logic [15:0]          rdLeft, next_rdLeft;
    logic [10:0]          rdPtr, next_rdPtr;
    logic                 rdSel, next_rdSel;
    sci_rsp_t             next_rsp;
    logic                 next_audioMute, next_frameSyncPin;
    logic                 next_decodeHalted, next_runStrobe;
    logic [15:0]          next_runAddr;
    logic                 next_cfgOverride, next_clkCfgActivate;
    logic                 next_softRst;
    logic                 wordDone, ctrlDone;
    logic [15:0]          word;
    logic                 regWe, memWe;
    logic [19:0]          regWd, memWd;
    logic [19:0]          memRdVal, regRdVal;
    logic [15:0]          curWord;

    assign rst = reset | softRst;
    assign word = {hiByte, host.data};
    // a word completes on its second byte to the write subaddress
    assign wordDone = host.valid && host.sub == SUB_WR && !wrHi;
    assign ctrlDone = host.valid && host.sub == SUB_CTRL && !wrHi;
    assign memRdVal = rdSel ? mem1[rdPtr] : mem0[rdPtr];
    assign regRdVal = (regNum == REG_PINS) ? 20'(pinLevel) : regFile[regNum];

    // Current response word; a bare read returns the frame counter
    always_comb begin
        case (rdMode)
            RD_STAT: curWord = statArr[rdPtr[5:0]];
            RD_REG:  curWord = rdSecond ? {12'h000, regRdVal[19:16]}
                                        : regRdVal[15:0];
            RD_MEM:  curWord = rdSecond ? {12'h000, memRdVal[19:16]}
                                        : memRdVal[15:0];
            default: curWord = mem0[FRAME_CNT_ADR][15:0];
        endcase
    end

    always_comb begin
        next_state = state;
        next_rdMode = rdMode;
        next_wrHi = wrHi;
        next_hiByte = hiByte;
        next_regNum = regNum;
        next_d0Nib = d0Nib;
        next_memSel = memSel;
        next_memRead = memRead;
        next_count = count;
        next_addr = addr;
        next_lowWord = lowWord;
        next_rdHi = rdHi;
        next_rdSecond = rdSecond;
        next_rdLeft = rdLeft;
        next_rdPtr = rdPtr;
        next_rdSel = rdSel;
        next_rsp = '{valid: 1'b0, data: rsp.data};
        next_audioMute = audioMute;
        next_decodeHalted = decodeHalted;
        next_runStrobe = 1'b0;
        next_runAddr = runAddr;
        next_cfgOverride = 1'b0;
        next_clkCfgActivate = 1'b0;
        next_softRst = 1'b0;
        regWe = 1'b0;
        regWd = {word, d0Nib};
        memWe = 1'b0;
        memWd = {word[3:0], lowWord};
        if (host.start) begin
            next_wrHi = 1'b1;
            next_rdHi = 1'b1;
        end else if (host.valid && host.sub != SUB_RD) begin
            next_wrHi = !wrHi;
            next_hiByte = host.data;
        end
        if (ctrlDone && word[CTRL_RST_BIT]) begin
            next_softRst = 1'b1;
        end
        if (wordDone) begin
            case (state)
                ST_CMD: begin
                    next_rdMode = RD_NONE;
                    case (word[15:12])
                        OP_RUN0, OP_RUN1: begin
                            next_runAddr = word;
                            if (word == RUN_HALT) begin
                                next_decodeHalted = 1'b1;
                            end
                            if (word >= RUN_DL_LO && word < RUN_DL_HI) begin
                                next_decodeHalted = 1'b0;
                                next_runStrobe = 1'b1;
                            end
                            next_cfgOverride = word == RUN_CFG_OVR;
                            next_clkCfgActivate = word == RUN_CLK_ACT;
                        end
                        OP_STAT: begin
                            next_rdPtr = {5'h00, word[11:6]};
                            next_rdLeft = {10'h000, word[5:0]};
                            if (word[5:0] != 6'h00) begin
                                next_rdMode = RD_STAT;
                            end
                        end
                        OP_REGWR: begin
                            next_regNum = word[11:4];
                            next_d0Nib = word[3:0];
                            next_state = ST_REGDAT;
                        end
                        OP_REGRD: begin
                            next_regNum = word[11:4];
                            next_rdMode = RD_REG;
                            next_rdSecond = 1'b0;
                            next_rdLeft = 16'h0001;
                        end
                        OP_MEMWR0, OP_MEMWR1, OP_MEMRD0, OP_MEMRD1: begin
                            // Bit 0 picks the memory, bit 2 the direction
                            next_memSel = word[12];
                            next_memRead = word[14];
                            next_state = ST_MCOUNT;
                        end
                        default: ;
                    endcase
                end
                ST_REGDAT: begin
                    regWe = 1'b1;
                    next_state = ST_CMD;
                end
                ST_MCOUNT: begin
                    next_count = word;
                    next_state = ST_MADDR;
                end
                ST_MADDR: begin
                    next_addr = word[10:0];
                    next_state = ST_CMD;
                    if (memRead && count != 16'h0000) begin
                        next_rdMode = RD_MEM;
                        next_rdSel = memSel;
                        next_rdPtr = word[10:0];
                        next_rdLeft = count;
                        next_rdSecond = 1'b0;
                    end else if (!memRead && count != 16'h0000) begin
                        next_state = ST_MDLOW;
                    end
                end
                ST_MDLOW: begin
                    next_lowWord = word;
                    next_state = ST_MDHIGH;
                end
                ST_MDHIGH: begin
                    memWe = 1'b1;
                    next_addr = addr + 11'h001;
                    next_count = count - 16'h0001;
                    next_state = (count == 16'h0001) ? ST_CMD : ST_MDLOW;
                end
                default: next_state = ST_CMD;
            endcase
        end
        if (regWe && regNum == REG_MUTE) begin
            next_audioMute = regWd == MUTE_ON;
        end
        // The answer byte always comes one cycle after the request
        if (rdReq) begin
            next_rsp.valid = 1'b1;
            next_rsp.data = rdHi ? curWord[15:8] : curWord[7:0];
            next_rdHi = !rdHi;
            if (!rdHi && rdMode != RD_NONE) begin
                if (rdMode == RD_STAT || rdSecond) begin
                    next_rdSecond = 1'b0;
                    next_rdPtr = rdPtr + 11'h001;
                    next_rdLeft = rdLeft - 16'h0001;
                    if (rdLeft == 16'h0001) begin
                        next_rdMode = RD_NONE;
                    end
                end else begin
                    next_rdSecond = 1'b1;
                end
            end
        end
        // A status read clears the sync pin, a new sync event wins
        next_frameSyncPin = frameSyncPin;
        if (wordDone && state == ST_CMD && word[15:12] == OP_STAT) begin
            next_frameSyncPin = 1'b0;
        end
        if (frameSyncEvent) begin
            next_frameSyncPin = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        pinS1 <= pioPins;
        pinS2 <= pinS1;
        pinS3 <= pinS2;
        if (pinS2 == pinS3) begin
            pinLevel <= pinS3;
        end
        // Soft reset only comes from the bus, so it clears on hard reset
        softRst <= reset ? 1'b0 : next_softRst;
        if (rst) begin
            state <= ST_CMD;
            rdMode <= RD_NONE;
            wrHi <= 1'b1;
            hiByte <= 8'h00;
            regNum <= 8'h00;
            d0Nib <= 4'h0;
            memSel <= 1'b0;
            memRead <= 1'b0;
            count <= 16'h0000;
            addr <= 11'h000;
            lowWord <= 16'h0000;
            rdHi <= 1'b1;
            rdSecond <= 1'b0;
            rdLeft <= 16'h0000;
            rdPtr <= 11'h000;
            rdSel <= 1'b0;
            rsp <= '0;
            audioMute <= 1'b0;
            frameSyncPin <= 1'b0;
            decodeHalted <= 1'b0;
            runStrobe <= 1'b0;
            runAddr <= 16'h0000;
            cfgOverride <= 1'b0;
            clkCfgActivate <= 1'b0;
            for (int i = 0; i < REG_COUNT; i++) begin
                regFile[i] <= REG_RST;
            end
        end else begin
            state <= next_state;
            rdMode <= next_rdMode;
            wrHi <= next_wrHi;
            hiByte <= next_hiByte;
            regNum <= next_regNum;
            d0Nib <= next_d0Nib;
            memSel <= next_memSel;
            memRead <= next_memRead;
            count <= next_count;
            addr <= next_addr;
            lowWord <= next_lowWord;
            rdHi <= next_rdHi;
            rdSecond <= next_rdSecond;
            rdLeft <= next_rdLeft;
            rdPtr <= next_rdPtr;
            rdSel <= next_rdSel;
            rsp <= next_rsp;
            audioMute <= next_audioMute;
            frameSyncPin <= next_frameSyncPin;
            decodeHalted <= next_decodeHalted;
            runStrobe <= next_runStrobe;
            runAddr <= next_runAddr;
            cfgOverride <= next_cfgOverride;
            clkCfgActivate <= next_clkCfgActivate;
            if (regWe) begin
                regFile[regNum] <= regWd;
            end
        end
    end

    // Storage is not reset; host writes take priority over firmware
    always_ff @(posedge core_clk) begin
        if (memWe && !memSel) begin
            mem0[addr] <= memWd;
        end else if (fw.valid && fw.target == 2'd0) begin
            mem0[fw.addr] <= fw.data;
        end
        if (memWe && memSel) begin
            mem1[addr] <= memWd;
        end else if (fw.valid && fw.target == 2'd1) begin
            mem1[fw.addr] <= fw.data;
        end
        if (fw.valid && fw.target == 2'd2) begin
            statArr[fw.addr[5:0]] <= fw.data[15:0];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_run(logic [15:0] a);
        wordDone && state == ST_CMD && word == a;
    endsequence
    sequence s_pulse(logic s);
        s ##1 !s;
    endsequence

    property p_mute;
        regWe && regNum == REG_MUTE && regWd == MUTE_ON |=> audioMute;
    endproperty
    a_mute: assert property (p_mute) else $error("mute not set");
    property p_syncclr;
        wordDone && state == ST_CMD && word[15:12] == OP_STAT
            && !frameSyncEvent |=> !frameSyncPin;
    endproperty
    a_syncclr: assert property (p_syncclr)
        else $error("sync pin not cleared");
    property p_halt;
        s_run(RUN_HALT) |=> decodeHalted && runAddr == 16'h0000;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt");
    property p_dlrun;
        wordDone && state == ST_CMD && word >= RUN_DL_LO && word < RUN_DL_HI
            |=> runStrobe && !decodeHalted && runAddr == $past(word);
    endproperty
    a_dlrun: assert property (p_dlrun) else $error("no run");
    property p_cfg;
        s_run(RUN_CFG_OVR) |=> s_pulse(cfgOverride);
    endproperty
    a_cfg: assert property (p_cfg) else $error("no override");
    property p_clk;
        s_run(RUN_CLK_ACT) |=> s_pulse(clkCfgActivate);
    endproperty
    a_clk: assert property (p_clk) else $error("no activate");
    property p_answer;
        rdReq |=> rsp.valid;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_default;
        rdReq && rdMode == RD_NONE && rdHi && !host.start
            |=> rsp.data == $past(mem0[FRAME_CNT_ADR][15:8]);
    endproperty
    a_default: assert property (p_default)
        else $error("bad default read");
    property p_stat;
        wordDone && state == ST_CMD && word[15:12] == OP_STAT
            && word[5:0] != 6'h00 |=> rdMode == RD_STAT
            && rdPtr == {5'h00, $past(word[11:6])};
    endproperty
    a_stat: assert property (p_stat) else $error("bad status setup");
endmodule

/* File: rtl/sci_pkg.sv */
// Shared constants and carriers of the serial command interpreter.
// Assumes byte-level framing is done by a two-wire slave in front of it.
package sci_pkg;
    localparam logic [7:0]  SUB_WR        = 8'h68;
    localparam logic [7:0]  SUB_RD        = 8'h69;
    localparam logic [7:0]  SUB_CTRL      = 8'h6a;
    localparam int          CTRL_RST_BIT  = 8;
    localparam logic [3:0]  OP_RUN0       = 4'h0;
    localparam logic [3:0]  OP_RUN1       = 4'h1;
    localparam logic [3:0]  OP_STAT       = 4'h3;
    localparam logic [3:0]  OP_REGWR      = 4'h9;
    localparam logic [3:0]  OP_MEMWR0     = 4'ha;
    localparam logic [3:0]  OP_MEMWR1     = 4'hb;
    localparam logic [3:0]  OP_REGRD      = 4'hd;
    localparam logic [3:0]  OP_MEMRD0     = 4'he;
    localparam logic [3:0]  OP_MEMRD1     = 4'hf;
    localparam logic [15:0] RUN_HALT      = 16'h0000;
    localparam logic [15:0] RUN_DL_LO     = 16'h1400;
    localparam logic [15:0] RUN_DL_HI     = 16'h1800;
    localparam logic [15:0] RUN_CFG_OVR   = 16'h0fcd;
    localparam logic [15:0] RUN_CLK_ACT   = 16'h0fcb;
    localparam logic [7:0]  REG_MUTE      = 8'haa;
    localparam logic [7:0]  REG_PINS      = 8'hc8;
    localparam logic [19:0] MUTE_ON       = 20'h00001;
    localparam logic [19:0] REG_RST       = 20'h00000;
    localparam logic [10:0] FRAME_CNT_ADR = 11'h300;
    localparam int          REG_COUNT     = 256;
    localparam int          MEM_WORDS     = 2048;
    localparam int          STAT_WORDS    = 64;
    localparam int          RESP_TIME_MS  = 4;
    localparam int          CLK_MHZ       = 100;
    localparam int          RESP_CYCLES   = RESP_TIME_MS * CLK_MHZ * 1000;

    typedef enum logic [2:0] {
        ST_CMD    = 3'b000,
        ST_MCOUNT = 3'b001,
        ST_MADDR  = 3'b011,
        ST_MDLOW  = 3'b010,
        ST_MDHIGH = 3'b110,
        ST_REGDAT = 3'b100
    } sci_state_t;

    typedef enum logic [1:0] {
        RD_NONE = 2'b00,
        RD_STAT = 2'b01,
        RD_REG  = 2'b11,
        RD_MEM  = 2'b10
    } sci_rdmode_t;

    // One byte of a bus transaction; start marks start or repeated start
    typedef struct packed {
        logic       start;
        logic       valid;
        logic [7:0] sub;
        logic [7:0] data;
    } sci_host_t;

    // Firmware side store: target 0 first memory, 1 second, 2 status
    typedef struct packed {
        logic        valid;
        logic [1:0]  target;
        logic [10:0] addr;
        logic [19:0] data;
    } sci_fw_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } sci_rsp_t;
endpackage

/* File: testbench/sci_host_model.sv */
// Host model: two-wire bus master seen at byte level by the command core.
// Assumes a free running core_clk; drives its signals on falling edges.
`timescale 1ns/100ps
module sci_host_model
    import sci_pkg::*;
(
    input  wire logic     core_clk,
    input  wire sci_rsp_t rsp,
    output sci_host_t     host,
    output logic          rdReq,
    output logic          replyLost
);
    initial begin
        host      = '0;
        rdReq     = 1'b0;
        replyLost = 1'b0;
    end

    // Start or repeated start followed by the subaddress
    task automatic open(input logic [7:0] sub);
        @(negedge core_clk);
        host.start = 1'b1;
        host.sub   = sub;
        @(negedge core_clk);
        host.start = 1'b0;
    endtask

    task automatic putByte(input logic [7:0] b);
        @(negedge core_clk);
        host.valid = 1'b1;
        host.data  = b;
        @(negedge core_clk);
        host.valid = 1'b0;
        // Released data lines must not look like a repeat of the byte
        host.data  = ~b;
    endtask

    // High byte before low byte, MSB first
    task automatic putWord(input logic [15:0] w);
        putByte(w[15:8]);
        putByte(w[7:0]);
    endtask

    task automatic getByte(output logic [7:0] b);
        @(negedge core_clk);
        rdReq = 1'b1;
        @(negedge core_clk);
        rdReq = 1'b0;
        // Answer is due at once; a short bound flags a lost reply
        for (int i = 0; i < 3 && rsp.valid !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        if (rsp.valid !== 1'b1) begin
            replyLost = 1'b1;
        end
        b = rsp.data;
    endtask

    task automatic getWord(output logic [15:0] w);
        getByte(w[15:8]);
        getByte(w[7:0]);
    endtask
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench of the serial command interpreter.
// Assumes the host model drives the byte port; firmware side driven here.
`timescale 1ns/100ps
module testbench
    import sci_pkg::*;
;
    typedef struct packed {
        logic [15:0] word;
        logic [3:0]  exp;
    } sci_run_row_t;
    // exp: halted, strobe, override, activate
    localparam sci_run_row_t RUNS [8] = '{
        '{16'h0000, 4'h8}, '{16'h1800, 4'h8}, '{16'h13ff, 4'h8},
        '{16'h1400, 4'h4}, '{16'h0000, 4'h8}, '{16'h17ff, 4'h4},
        '{16'h0fcd, 4'h2}, '{16'h0fcb, 4'h1}};

    logic        core_clk;
    logic        reset;
    logic        rdReq;
    logic        replyLost;
    logic        frameSyncEvent;
    logic [7:0]  pioPins;
    sci_host_t   host;
    sci_fw_t     fw;
    sci_rsp_t    rsp;
    logic        audioMute;
    logic        frameSyncPin;
    logic        decodeHalted;
    logic        runStrobe;
    logic [15:0] runAddr;
    logic        cfgOverride;
    logic        clkCfgActivate;
    logic [15:0] w;
    int          failures;
    int          checks_done;

    sci_core u_dut (
        .core_clk(core_clk), .reset(reset), .host(host), .rdReq(rdReq),
        .fw(fw), .frameSyncEvent(frameSyncEvent), .pioPins(pioPins),
        .rsp(rsp), .audioMute(audioMute), .frameSyncPin(frameSyncPin),
        .decodeHalted(decodeHalted), .runStrobe(runStrobe),
        .runAddr(runAddr), .cfgOverride(cfgOverride),
        .clkCfgActivate(clkCfgActivate));

    sci_host_model u_host (
        .core_clk(core_clk), .rsp(rsp), .host(host), .rdReq(rdReq),
        .replyLost(replyLost));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim;
        chk("reply in time", 32'h0, {31'h0, replyLost});
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wrCmd(input logic [15:0] cmd);
        u_host.open(SUB_WR);
        u_host.putWord(cmd);
    endtask

    task automatic regWr(input logic [7:0] r, input logic [19:0] v);
        wrCmd({OP_REGWR, r, v[3:0]});
        u_host.putWord(v[19:4]);
    endtask

    task automatic regRd(input logic [7:0] r, input logic [19:0] v);
        logic [15:0] lo;
        logic [15:0] hi;
        wrCmd({OP_REGRD, r, 4'h0});
        u_host.open(SUB_RD);
        u_host.getWord(lo);
        u_host.getWord(hi);
        chk("register read", {12'h000, v}, {hi, lo});
    endtask

    // Write or read a memory block; for reads v holds the expected words
    task automatic memCmd(input logic [3:0] op, input logic [10:0] a,
                          input logic [19:0] v[$]);
        logic [15:0] lo;
        logic [15:0] hi;
        wrCmd({op, 12'h000});
        u_host.putWord(16'(v.size()));
        u_host.putWord({5'h00, a});
        if (op[2]) begin
            u_host.open(SUB_RD);
        end
        foreach (v[i]) begin
            if (op[2]) begin
                u_host.getWord(lo);
                u_host.getWord(hi);
                chk("memory word", {12'h000, v[i]}, {hi, lo});
            end else begin
                u_host.putWord(v[i][15:0]);
                u_host.putWord({12'h000, v[i][19:16]});
            end
        end
    endtask

    // Bare read with no command before it
    task automatic dflt(input logic [15:0] exp);
        u_host.open(SUB_RD);
        u_host.getWord(w);
        chk("frame counter", {16'h0, exp}, {16'h0, w});
    endtask

    task automatic fwPut(input logic [5:0] a, input logic [15:0] d);
        @(negedge core_clk);
        fw = '{1'b1, 2'd2, {5'h00, a}, {4'h0, d}};
        @(negedge core_clk);
        fw.valid = 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        end_sim();
    end

    initial begin
        failures       = 0;
        checks_done    = 0;
        reset          = 1'b1;
        fw             = '0;
        frameSyncEvent = 1'b0;
        pioPins        = 8'h5a;
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        chk("reset outputs", 32'h0, {10'h0, audioMute, frameSyncPin,
            decodeHalted, runStrobe, cfgOverride, clkCfgActivate, runAddr});
        $display("test reset done");
        foreach (RUNS[i]) begin
            wrCmd(RUNS[i].word);
            chk("run outputs", {28'h0, RUNS[i].exp}, {28'h0, decodeHalted,
                runStrobe, cfgOverride, clkCfgActivate});
            chk("run address", {16'h0, RUNS[i].word}, {16'h0, runAddr});
        end
        // An unknown command nibble must leave the run state alone
        wrCmd(16'h2abc);
        chk("ignored command", 32'h0fcb, {16'h0, runAddr});
        $display("test run table done");
        regWr(REG_MUTE, MUTE_ON);
        chk("mute", 32'h1, {31'h0, audioMute});
        regRd(REG_MUTE, MUTE_ON);
        regWr(8'h55, 20'h17c63);
        regRd(8'h55, 20'h17c63);
        regRd(REG_PINS, 20'h0005a);
        u_host.open(SUB_CTRL);
        u_host.putWord(16'h0100);
        repeat (3) @(negedge core_clk);
        chk("mute after soft reset", 32'h0, {31'h0, audioMute});
        regRd(8'h55, REG_RST);
        // Pin readback must follow a change once it has settled
        pioPins = 8'ha5;
        repeat (4) @(negedge core_clk);
        regRd(REG_PINS, 20'h000a5);
        $display("test registers done");
        memCmd(OP_MEMWR0, 11'h2ff, {20'h12345, 20'habcde});
        dflt(16'hbcde);
        memCmd(OP_MEMRD0, 11'h2ff, {20'h12345, 20'habcde});
        memCmd(OP_MEMWR1, 11'h300, {20'h0f0f0});
        dflt(16'hbcde);
        memCmd(OP_MEMRD1, 11'h300, {20'h0f0f0});
        $display("test memories done");
        fwPut(6'd2, 16'h1111);
        fwPut(6'd3, 16'h2222);
        @(negedge core_clk);
        frameSyncEvent = 1'b1;
        @(negedge core_clk);
        frameSyncEvent = 1'b0;
        chk("sync pin set", 32'h1, {31'h0, frameSyncPin});
        wrCmd({OP_STAT, 6'd2, 6'd2});
        chk("sync pin cleared", 32'h0, {31'h0, frameSyncPin});
        u_host.open(SUB_RD);
        u_host.getWord(w);
        chk("status word 2", 32'h1111, {16'h0, w});
        u_host.getWord(w);
        chk("status word 3", 32'h2222, {16'h0, w});
        u_host.getWord(w);
        chk("read past count", 32'hbcde, {16'h0, w});
        $display("test status done");
        end_sim();
    end
endmodule
